// file: spi_master_consts.svh
`ifndef SPI_MASTER_CONSTS_SVH
`define SPI_MASTER_CONSTS_SVH

// register indices; the byte address is four times the index
`define BUF_INDEX 8'h13
`define CTRL_INDEX 8'h14
`define STAT_INDEX 8'h15
`define MASK_INDEX 8'h16

// port control register fields
`define CTRL_RATE_LSB 0
`define CTRL_EDGE_BIT 2
`define CTRL_PHASE_BIT 3
`define CTRL_POL_BIT 4
`define CTRL_RXONLY_BIT 5
`define CTRL_EN_BIT 6

// status and mask fields
`define STAT_DONE_BIT 0
`define STAT_COLL_BIT 1

// reset values
`define CTRL_RESET 8'h00
`define BUF_RESET 8'h00
`define STAT_RESET 2'h0
`define MASK_RESET 2'h0

// bit rate select codes
`define RATE_DIV4 2'h0
`define RATE_DIV16 2'h1
`define RATE_DIV64 2'h2
`define RATE_TIMER 2'h3

// half bit lengths in system clocks for fosc/4, fosc/16, fosc/64
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20

// eight bits take sixteen clock half periods
`define XFER_HALVES 5'h10

`endif

// file: spi_master_pkg.sv
package spi_master_pkg;

    // axi4-lite request from the master
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } axi_req_t;

    // axi4-lite answer from the slave
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    // serial pins driven by the master
    typedef struct packed {
        logic clk;
        logic data;
        logic data_oe;
    } serial_pins_t;

    typedef enum logic {
        XFER_IDLE,
        XFER_RUN
    } xfer_state_t;

    typedef struct packed {
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [7:0] wdata;
        logic wlane;
        logic bvalid;
        logic berr;
        logic rvalid;
        logic rerr;
        logic [7:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] buffer;
        logic [1:0] status;
        logic [1:0] mask;
        xfer_state_t st;
        logic [4:0] phase;
        logic [7:0] tx;
        logic [7:0] rx;
        logic dout;
        logic sck_active;
        logic [1:0] sample_dly;
    } core_state_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } rate_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

endpackage

// file: spi_bit_sync.sv
`timescale 1ns/1ps
`include "spi_master_consts.svh"

// two flip-flop synchroniser for a pin level
module spi_bit_sync
    import spi_master_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // level
    input wire logic level_in,
    output logic level_out
);

    sync_state_t s_q;
    sync_state_t s_d;

    // first stage feeds only the second
    always_comb begin
        s_d = s_q;
        s_d.s1 = level_in;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.s2;

endmodule // spi_bit_sync

// file: spi_rate_gen.sv
`timescale 1ns/1ps
`include "spi_master_consts.svh"

// half bit enable pulses for the serial clock
module spi_rate_gen
    import spi_master_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // control
    input wire logic run_in,
    input wire logic [1:0] rate_sel_in,
    input wire logic timer_tick_in,
    // half bit pulse
    output logic half_tick_out
);

    rate_state_t s_q;
    rate_state_t s_d;
    logic [5:0] half_len;

    // half bit length for the selected divider
    always_comb begin
        half_len = `HALF_DIV64;
        if (rate_sel_in == `RATE_DIV4) begin
            half_len = `HALF_DIV4;
        end else if (rate_sel_in == `RATE_DIV16) begin
            half_len = `HALF_DIV16;
        end
    end

    // held at zero between transfers so the first half bit at a divided rate is full length
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run_in) begin
            s_d.cnt = 6'h00;
        end else if (rate_sel_in == `RATE_TIMER) begin
            s_d.tick = timer_tick_in; // each timer pulse is a half bit
        end else if (s_q.cnt == half_len - 6'h01) begin
            s_d.cnt = 6'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign half_tick_out = s_q.tick;

endmodule // spi_rate_gen

// file: spi_master_transfer.sv
`timescale 1ns/1ps
`include "spi_master_consts.svh"

module spi_master_transfer
    import spi_master_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // register bus
    input wire axi_req_t axi_req_in,
    output axi_rsp_t axi_rsp_out,
    // second timer output pulse, same clock
    input wire logic second_timer_tick_in,
    // serial link
    output serial_pins_t serial_out,
    input wire logic serial_data_in,
    // interrupt
    output logic irq_out
);

    localparam logic [7:0] BUF_ADDR = 8'(`BUF_INDEX * 4);
    localparam logic [7:0] CTRL_ADDR = 8'(`CTRL_INDEX * 4);
    localparam logic [7:0] STAT_ADDR = 8'(`STAT_INDEX * 4);
    localparam logic [7:0] MASK_ADDR = 8'(`MASK_INDEX * 4);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    core_state_t s_q;
    core_state_t s_d;

    logic din_sync;
    logic half_tick;
    logic aw_ready;
    logic w_ready;
    logic ar_ready;
    logic start;
    logic [1:0] events;
    logic [4:0] k;
    logic lead;
    logic change;
    logic sample;
    logic [7:0] rx_next;
    logic [7:0] rd_word;
    logic rd_err;
    logic cke;
    logic sample_phase;

    // data input crosses into the clock domain first
    spi_bit_sync u_din_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .level_in(serial_data_in),
        .level_out(din_sync)
    );

    // half bit enables at the selected rate
    spi_rate_gen u_rate (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .run_in(s_q.st == XFER_RUN),
        .rate_sel_in(s_q.ctrl[`CTRL_RATE_LSB +: 2]),
        .timer_tick_in(second_timer_tick_in),
        .half_tick_out(half_tick)
    );

    // one write and one read in flight; address and data in either order
    assign aw_ready = !s_q.aw_have && !s_q.bvalid;
    assign w_ready = !s_q.w_have && !s_q.bvalid;
    assign ar_ready = !s_q.rvalid;
    assign cke = s_q.ctrl[`CTRL_EDGE_BIT];
    assign sample_phase = s_q.ctrl[`CTRL_PHASE_BIT];

    // read decode; unmapped addresses answer with an error and zero data
    always_comb begin
        rd_word = 8'h00;
        rd_err = 1'b0;
        if (axi_req_in.araddr[7:0] == BUF_ADDR) begin
            rd_word = s_q.buffer;
        end else if (axi_req_in.araddr[7:0] == CTRL_ADDR) begin
            rd_word = s_q.ctrl;
        end else if (axi_req_in.araddr[7:0] == STAT_ADDR) begin
            rd_word = {6'h00, s_q.status};
        end else if (axi_req_in.araddr[7:0] == MASK_ADDR) begin
            rd_word = {6'h00, s_q.mask};
        end else begin
            rd_err = 1'b1;
        end
        if (axi_req_in.araddr[31:8] != 24'h000000) begin
            rd_word = 8'h00;
            rd_err = 1'b1;
        end
    end

    // bus, registers and shift engine in one next-state process
    always_comb begin
        s_d = s_q;
        start = 1'b0;
        events = 2'h0;
        k = s_q.phase + 5'h01;
        lead = k[0];
        change = 1'b0;
        sample = 1'b0;
        rx_next = s_q.rx;

        // capture address and data as each arrives
        if (axi_req_in.awvalid && aw_ready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = axi_req_in.awaddr[7:0];
            if (axi_req_in.awaddr[31:8] != 24'h000000) begin
                s_d.awaddr = 8'hFF; // forces the unmapped answer
            end
        end
        if (axi_req_in.wvalid && w_ready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = axi_req_in.wdata[7:0];
            s_d.wlane = axi_req_in.wstrb[0];
        end
        if (s_q.bvalid && axi_req_in.bready) begin
            s_d.bvalid = 1'b0;
        end

        // perform the write once both halves are held
        if (s_q.aw_have && s_q.w_have) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.berr = 1'b0;
            if (s_q.awaddr == BUF_ADDR) begin
                if (s_q.wlane) begin
                    if (s_q.st == XFER_RUN) begin
                        events[`STAT_COLL_BIT] = 1'b1; // byte dropped
                    end else begin
                        s_d.buffer = s_q.wdata;
                        start = s_q.ctrl[`CTRL_EN_BIT];
                    end
                end
            end else if (s_q.awaddr == CTRL_ADDR) begin
                if (s_q.wlane) begin
                    s_d.ctrl = s_q.wdata;
                end
            end else if (s_q.awaddr == STAT_ADDR) begin
                if (s_q.wlane) begin
                    s_d.status = s_q.status & ~s_q.wdata[1:0];
                end
            end else if (s_q.awaddr == MASK_ADDR) begin
                if (s_q.wlane) begin
                    s_d.mask = s_q.wdata[1:0];
                end
            end else begin
                s_d.berr = 1'b1;
            end
        end

        // read answer a cycle after the address is taken
        if (s_q.rvalid && axi_req_in.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (axi_req_in.arvalid && ar_ready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rerr = rd_err;
        end

        // shift engine
        case (s_q.st)
            XFER_IDLE: begin
                s_d.sck_active = 1'b0;
                s_d.phase = 5'h00;
                if (start) begin
                    s_d.st = XFER_RUN;
                    s_d.rx = 8'h00;
                    if (cke) begin
                        // first bit set up before any clock edge
                        s_d.dout = s_q.wdata[7];
                        s_d.tx = {s_q.wdata[6:0], 1'b0};
                    end else begin
                        s_d.tx = s_q.wdata;
                    end
                end
            end
            XFER_RUN: begin
                if (s_q.phase == `XFER_HALVES) begin
                    // clock already idle; wait for the last delayed sample
                    if (s_q.sample_dly == 2'h0) begin
                        s_d.st = XFER_IDLE;
                        s_d.buffer = s_q.rx;
                        events[`STAT_DONE_BIT] = 1'b1;
                    end
                end else if (half_tick) begin
                    // odd half ticks are leading edges, even trailing
                    s_d.phase = k;
                    s_d.sck_active = !s_q.sck_active;
                    if (cke) begin
                        change = !lead && (k != `XFER_HALVES);
                    end else begin
                        change = lead;
                    end
                    if (!sample_phase) begin
                        // middle of bit: the edge opposite the change
                        sample = cke ? lead : !lead;
                    end else if (cke) begin
                        sample = !lead; // end of bit
                    end else begin
                        sample = (lead && (k != 5'h01))
                            || (k == `XFER_HALVES);
                    end
                    if (change) begin
                        s_d.dout = s_q.tx[7];
                        s_d.tx = {s_q.tx[6:0], 1'b0};
                    end
                    if (k == `XFER_HALVES) begin
                        s_d.sck_active = 1'b0;
                    end
                end
            end
            default: begin
                s_d.st = XFER_IDLE;
            end
        endcase

        // the synchroniser shows the pin two cycles late, so the strobe is
        // delayed to match; at the fastest rate the pin is still caught as
        // it stood at the sampling clock edge
        s_d.sample_dly = {s_q.sample_dly[0], sample};
        if (s_q.sample_dly[1]) begin
            // input keeps shifting with the output off
            rx_next = {s_q.rx[6:0], din_sync};
            s_d.rx = rx_next;
        end

        // a hardware event wins over a clear in the same cycle
        s_d.status = s_d.status | events;
    end

    // one register for all state
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
            s_q.ctrl <= `CTRL_RESET;
            s_q.buffer <= `BUF_RESET;
            s_q.status <= `STAT_RESET;
            s_q.mask <= `MASK_RESET;
            s_q.st <= XFER_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answers
    always_comb begin
        axi_rsp_out.awready = aw_ready;
        axi_rsp_out.wready = w_ready;
        axi_rsp_out.bvalid = s_q.bvalid;
        axi_rsp_out.bresp = s_q.berr ? RESP_SLVERR : RESP_OKAY;
        axi_rsp_out.arready = ar_ready;
        axi_rsp_out.rvalid = s_q.rvalid;
        axi_rsp_out.rdata = {24'h000000, s_q.rdata};
        axi_rsp_out.rresp = s_q.rerr ? RESP_SLVERR : RESP_OKAY;
    end

    // pins; idle level of the clock is the polarity bit itself
    always_comb begin
        serial_out.clk = s_q.ctrl[`CTRL_POL_BIT] ^ s_q.sck_active;
        serial_out.data = s_q.dout;
        // receive-only leaves the pin undriven, transfers still run
        serial_out.data_oe = s_q.ctrl[`CTRL_EN_BIT]
            && !s_q.ctrl[`CTRL_RXONLY_BIT];
    end

    // level interrupt while any unmasked flag stands
    assign irq_out = |(s_q.status & s_q.mask);

endmodule // spi_master_transfer

// file: spi_master_transfer_checker.sv
`timescale 1ns/1ps
`include "spi_master_consts.svh"

// port level properties of the transfer block
module spi_master_transfer_checker
    import spi_master_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // watched ports
    input wire axi_req_t axi_req_in,
    input wire axi_rsp_t axi_rsp_out,
    input wire logic second_timer_tick_in,
    input wire serial_pins_t serial_out,
    input wire logic serial_data_in,
    input wire logic irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic [7:0] aw_q;
    logic [7:0] wd_q;
    logic [7:0] ctrl_q;
    logic [7:0] mask_q;
    logic [3:0] tog_q;
    logic [5:0] gap_q;
    logic sck_q;
    logic sck_chg;
    logic cnt_chg;
    logic [5:0] half;
    // polarity writes move the clock too, so they are not counted
    assign sck_chg = serial_out.clk != sck_q;
    assign cnt_chg = sck_chg && !(!axi_rsp_out.awready && aw_q == 8'h50)
        && (tog_q != 4'h0 || serial_out.clk != ctrl_q[4]);
    assign half = ctrl_q[1:0] == `RATE_DIV4 ? `HALF_DIV4 :
        ctrl_q[1:0] == `RATE_DIV16 ? `HALF_DIV16 : `HALF_DIV64;
    // shadow of control and mask, clock edge count and spacing
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_q <= 8'h00;
            wd_q <= 8'h00;
            ctrl_q <= 8'h00;
            mask_q <= 8'h00;
            tog_q <= 4'h0;
            gap_q <= 6'h00;
            sck_q <= 1'b0;
        end else begin
            if (axi_req_in.awvalid && axi_rsp_out.awready) begin
                aw_q <= axi_req_in.awaddr[7:0];
            end
            if (axi_req_in.wvalid && axi_rsp_out.wready) begin
                wd_q <= axi_req_in.wdata[7:0];
            end
            if (axi_rsp_out.bvalid && axi_req_in.bready
                && axi_rsp_out.bresp == 2'h0) begin
                if (aw_q == 8'h50) begin
                    ctrl_q <= wd_q;
                end
                if (aw_q == 8'h58) begin
                    mask_q <= wd_q;
                end
            end
            sck_q <= serial_out.clk;
            gap_q <= sck_chg ? 6'h01 : gap_q + 6'h01;
            if (cnt_chg) begin
                tog_q <= tog_q + 4'h1;
            end
        end
    end
    a_write_answer: assert property (axi_req_in.awvalid && axi_req_in.wvalid
        && axi_rsp_out.awready && axi_rsp_out.wready |=> ##1
        axi_rsp_out.bvalid) else $error("write answer late");
    a_read_answer: assert property (axi_req_in.arvalid && axi_rsp_out.arready
        |=> axi_rsp_out.rvalid) else $error("read answer late");
    a_rvalid_hold: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
        |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
        else $error("read data dropped");
    a_ready_low: assert property (axi_rsp_out.bvalid |->
        !axi_rsp_out.awready && !axi_rsp_out.wready)
        else $error("ready during response");
    a_clock_idle: assert property (
        tog_q == 4'h0 && !sck_chg && axi_rsp_out.awready
        |-> serial_out.clk == ctrl_q[4]) else $error("idle clock level");
    a_rate_gap: assert property (
        cnt_chg && tog_q != 4'h0 && ctrl_q[1:0] != `RATE_TIMER
        |-> gap_q == half) else $error("half bit length");
    a_lead_stable: assert property (
        cnt_chg && !tog_q[0] && ctrl_q[2] |-> $stable(serial_out.data))
        else $error("data moved on leading edge");
    a_done_count: assert property (
        $rose(irq_out) && !mask_q[1] |=> tog_q == 4'h0)
        else $error("done before sixteen edges");
    a_rxonly_off: assert property (
        axi_rsp_out.awready && ctrl_q[5] |-> !serial_out.data_oe)
        else $error("data driven in receive only");
    c_done: cover property ($rose(irq_out));
    c_timer: cover property (cnt_chg && ctrl_q[1:0] == `RATE_TIMER);
    c_slverr: cover property (axi_rsp_out.rvalid && axi_rsp_out.rresp == 2'h2);
endmodule // spi_master_transfer_checker

bind spi_master_transfer spi_master_transfer_checker checker_inst (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .axi_req_in(axi_req_in),
    .axi_rsp_out(axi_rsp_out),
    .second_timer_tick_in(second_timer_tick_in),
    .serial_out(serial_out),
    .serial_data_in(serial_data_in),
    .irq_out(irq_out)
);

// file: spi_link_slave_model.sv
`timescale 1ns/1ps

// far end of the link: a plain shift register slave
module spi_link_slave_model (
    // link
    input wire logic sck_in,
    input wire logic mosi_in,
    output logic miso_out,
    // mode and data from the bench
    input wire logic cpol_in,
    input wire logic cke_in,
    input wire logic load_in,
    input wire logic [7:0] tx_in,
    output logic [7:0] rx_out
);
    int idx = 0;
    int n = 0;
    logic act = 1'b0;
    initial begin
        miso_out = 1'b0;
        rx_out = 8'h00;
    end
    // first bit shown at once; harmless on an idle line
    always @(posedge load_in) begin
        act = 1'b1;
        n = 0;
        idx = cke_in ? 6 : 7;
        miso_out = tx_in[7];
    end
    // shift on the change edge, capture on the other, then let go
    always @(sck_in) begin
        if (act && ((sck_in != cpol_in) != cke_in)) begin
            if (idx >= 0) begin
                miso_out = tx_in[idx];
                idx--;
            end else begin
                miso_out = ~miso_out;
                act = 1'b0;
            end
        end else if (act) begin
            rx_out = {rx_out[6:0], mosi_in};
            n++;
            if (n == 8 && !cke_in) begin
                miso_out = ~miso_out;
                act = 1'b0;
            end
        end
    end
endmodule // spi_link_slave_model

// file: spi_master_transfer_bench.sv
`timescale 1ns/1ps
`include "spi_master_consts.svh"

// register level tests of the transfer block
module spi_master_transfer_bench
    import spi_master_pkg::*;
;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    axi_req_t req = '0;
    axi_rsp_t rsp;
    serial_pins_t ser;
    logic tick = 1'b0;
    logic irq;
    logic load = 1'b0;
    logic cpol = 1'b0;
    logic cke = 1'b0;
    logic [7:0] stx = 8'h00;
    logic [7:0] srx;
    logic miso;
    logic mosi;
    logic [1:0] tcnt = 2'h0;
    logic [7:0] rd;
    logic [1:0] rs;
    logic [7:0] ctl [5] = '{8'h47, 8'h51, 8'h5E, 8'h48, 8'h67};
    logic [7:0] tx [5] = '{8'hA5, 8'h96, 8'h5A, 8'h0F, 8'h00};
    logic [7:0] rx [5] = '{8'h3C, 8'hC3, 8'h81, 8'h2D, 8'h6E};
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int k;
    always #50 clk_in = ~clk_in;
    // pull-up holds the data line while the master lets go
    assign mosi = ser.data_oe ? ser.data : 1'b1;
    spi_master_transfer spi_master_transfer_inst (.clk_in(clk_in),
        .nrst_in(nrst_in), .axi_req_in(req), .axi_rsp_out(rsp),
        .second_timer_tick_in(tick), .serial_out(ser),
        .serial_data_in(miso), .irq_out(irq));
    spi_link_slave_model spi_link_slave_model_inst (.sck_in(ser.clk),
        .mosi_in(mosi), .miso_out(miso), .cpol_in(cpol), .cke_in(cke),
        .load_in(load), .tx_in(stx), .rx_out(srx));
    // timer pulse every fourth clock gives an 800 ns link clock
    always @(posedge clk_in) begin
        tcnt <= tcnt + 2'h1;
        tick <= tcnt == 2'h3;
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // handshakes are judged on values settled before the edge
    task automatic wr(input logic [7:0] idx, d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk_in);
        req.awvalid <= 1'b1;
        req.awaddr <= {22'h0, idx, 2'h0};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk_in);
            ta = req.awvalid & rsp.awready;
            tw = req.wvalid & rsp.wready;
            tb = rsp.bvalid;
            r = rsp.bresp;
            @(posedge clk_in);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
        end
        req.bready <= 1'b0;
    endtask
    // ready is raised once the address is taken, so it is already high in the answer's first cycle
    task automatic rdr(input logic [7:0] idx, output logic [7:0] d,
        output logic [1:0] r);
        logic ta, tr;
        @(posedge clk_in);
        req.arvalid <= 1'b1;
        req.araddr <= {22'h0, idx, 2'h0};
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk_in);
            ta = req.arvalid & rsp.arready;
            tr = rsp.rvalid & req.rready;
            d = rsp.rdata[7:0];
            r = rsp.rresp;
            @(posedge clk_in);
            if (ta) req.arvalid <= 1'b0;
            if (ta) req.rready <= 1'b1;
        end
        req.rready <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        rdr(`CTRL_INDEX, rd, rs);
        chk("control reset", `CTRL_RESET, rd);
        rdr(`BUF_INDEX, rd, rs);
        chk("buffer reset", `BUF_RESET, rd);
        rdr(8'h17, rd, rs);
        chk("unmapped read", 8'h02, {6'h0, rs});
        wr(8'h17, 8'hFF, rs);
        chk("unmapped write", 8'h02, {6'h0, rs});
        wr(`MASK_INDEX, 8'h01, rs);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            wr(`CTRL_INDEX, ctl[i], rs);
            cpol <= ctl[i][4];
            cke <= ctl[i][2];
            stx <= rx[i];
            load <= 1'b1;
            @(posedge clk_in);
            load <= 1'b0;
            chk("idle clock", {7'h0, ctl[i][4]}, {7'h0, ser.clk});
            wr(`BUF_INDEX, tx[i], rs);
            if (ser.clk === ctl[i][4] && ctl[i][2] && !ctl[i][5]) begin
                chk("first bit", {7'h0, tx[i][7]}, {7'h0, ser.data});
            end
            // a buffer write while busy is dropped and flags a collision
            if (i == 4) begin
                wr(`BUF_INDEX, 8'hC3, rs);
                chk("busy write", 8'h00, {6'h0, rs});
            end
            k = 0;
            while (irq !== 1'b1 && k < 2000) begin
                @(posedge clk_in);
                k++;
            end
            chk("irq raised", 8'h01, {7'h0, irq});
            chk("clock back", {7'h0, ctl[i][4]}, {7'h0, ser.clk});
            rdr(`STAT_INDEX, rd, rs);
            chk("status done", (i == 4) ? 8'h03 : 8'h01, rd);
            rdr(`BUF_INDEX, rd, rs);
            chk("received", rx[i], rd);
            if (!ctl[i][5]) begin
                chk("sent", tx[i], srx);
            end else begin
                chk("output enable", 8'h00, {7'h0, ser.data_oe});
            end
            wr(`MASK_INDEX, 8'h00, rs);
            @(posedge clk_in);
            chk("irq masked", 8'h00, {7'h0, irq});
            wr(`MASK_INDEX, 8'h01, rs);
            wr(`STAT_INDEX, 8'h01, rs);
            @(posedge clk_in);
            chk("irq cleared", 8'h00, {7'h0, irq});
            $display("test transfer %0d done", i);
        end
        final_report();
    end
endmodule // spi_master_transfer_bench
